// file: i2csp_pkg.sv
// Purpose: shared constants and types for the two-wire slave register port
// Assumes: bus id upper part fixed, lowest bit from the id-select pin
// Notes: link side runs on link_clk, register side on clk
package i2csp_pkg;

	// fixed upper six bits of the 7-bit bus id (b110100X)
	localparam logic [5:0] BUS_ID_UPPER = 6'h34;
	// bits in one byte on the bus
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// direction bit value that selects a read
	localparam logic DIR_READ = 1'b1;
	// register pointer after reset
	localparam logic [7:0] PTR_RESET = 8'h00;
	// held read data after reset
	localparam logic [7:0] RDATA_RESET = 8'h00;
	// idle level of a released bus line
	localparam logic LINE_IDLE = 1'b1;
	// largest bus clock rate served, in kHz
	localparam int BUS_RATE_MAX_KHZ = 400;

	typedef logic [7:0] i2csp_byte_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK,
		ST_IGNORE
	} i2csp_state_t;

	typedef enum logic [1:0] {
		PH_ADDR,
		PH_PTR,
		PH_DATA
	} i2csp_phase_t;

	// one register access handed from the link side to the register side
	typedef struct packed {
		logic write;
		logic [7:0] addr;
		logic [7:0] data;
	} i2csp_req_t;

	// sampled levels of the two bus lines
	typedef struct packed {
		logic scl;
		logic sda;
	} i2csp_line_t;

endpackage : i2csp_pkg

// file: i2csp_slave_port.sv
// Purpose: two-wire bus slave giving a bus master access to internal registers
// Assumes: link_clk is far faster than the bus clock; user registers answer a
//          read strobe with data in the same clk cycle
// Notes: pins are split into input, output and output enable; the bench
//        resolves the open-drain wires
// Contract
// - falling data while clock high starts transaction
// - rising data while clock high ends transaction
// - busy from start to stop; restart resets address
// - bytes are eight bits, bursts unlimited
// - receiver holds data low through ack pulse
// - slave may hold clock low until ready
// - seven-bit id plus direction, msb first
// - direction zero writes, one reads
// - data changes only while clock is low
// - matching write id acknowledged at ninth clock
// - first write byte sets pointer, next stored
// - further write bytes go to incremented pointer
// - restart with read id returns pointed byte
// - master nack then stop ends read driving
// - master ack increments pointer, sends next byte
// - id lowest bit follows the id-select pin
// - works at bus rates up to 400kHz
module i2csp_slave_port (
	input wire logic clk,
	input wire logic rstn,
	input wire logic link_clk,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic bus_id_select_pin,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output i2csp_pkg::i2csp_byte_t reg_addr,
	output i2csp_pkg::i2csp_byte_t reg_wdata,
	input wire i2csp_pkg::i2csp_byte_t reg_rdata,
	output logic bus_busy
);
	import i2csp_pkg::*;

	// link domain reset: asserts at once, releases on link_clk
	logic [1:0] lrst_q;
	logic lrstn;

	// link domain state
	i2csp_line_t line_m_q;
	i2csp_line_t line_s_q;
	i2csp_line_t line_p_q;
	logic id_m_q;
	logic id_s_q;
	i2csp_state_t st_q;
	i2csp_phase_t ph_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] ptr_q;
	logic dir_q;
	logic mack_q;
	logic busy_q;
	logic sda_oe_q;
	logic scl_oe_q;
	logic pend_q;
	i2csp_req_t req_q;
	logic req_tgl_q;
	logic ack_m_q;
	logic ack_s_q;
	logic ack_p_q;

	// register domain state
	logic req_m_q;
	logic req_s_q;
	logic req_p_q;
	logic ack_tgl_q;
	logic [7:0] rdata_hold_q;
	logic busy_m_q;

	assign lrstn = lrst_q[1];

	always_ff @(posedge link_clk or negedge rstn) begin
		if (!rstn) begin
			lrst_q <= 2'h0;
		end else begin
			lrst_q <= {lrst_q[0], 1'b1};
		end
	end

	// ---------------- link side ----------------

	// bus lines and the id pin pass two flops before use
	always_ff @(posedge link_clk or negedge lrstn) begin
		if (!lrstn) begin
			line_m_q <= '{scl: LINE_IDLE, sda: LINE_IDLE};
			line_s_q <= '{scl: LINE_IDLE, sda: LINE_IDLE};
			line_p_q <= '{scl: LINE_IDLE, sda: LINE_IDLE};
			id_m_q <= 1'b0;
			id_s_q <= 1'b0;
		end else begin
			line_m_q <= '{scl: scl_i, sda: sda_i};
			line_s_q <= line_m_q;
			line_p_q <= line_s_q;
			id_m_q <= bus_id_select_pin;
			id_s_q <= id_m_q;
		end
	end

	// returning handshake from the register side
	always_ff @(posedge link_clk or negedge lrstn) begin
		if (!lrstn) begin
			ack_m_q <= 1'b0;
			ack_s_q <= 1'b0;
			ack_p_q <= 1'b0;
		end else begin
			ack_m_q <= ack_tgl_q;
			ack_s_q <= ack_m_q;
			ack_p_q <= ack_s_q;
		end
	end

	wire start_det = line_s_q.scl & line_p_q.scl & line_p_q.sda & ~line_s_q.sda;
	wire stop_det = line_s_q.scl & line_p_q.scl & ~line_p_q.sda & line_s_q.sda;
	wire scl_rise = line_s_q.scl & ~line_p_q.scl;
	wire scl_fall = ~line_s_q.scl & line_p_q.scl;
	wire ack_evt = ack_s_q ^ ack_p_q;
	wire [6:0] own_id = {BUS_ID_UPPER, id_s_q};
	wire id_hit = (shift_q[7:1] == own_id);
	wire byte_done = (bit_cnt_q == BYTE_BITS);
	wire last_tx_bit = (bit_cnt_q == BYTE_BITS - 4'h1);
	wire rx_end = (st_q == ST_RX) & scl_fall & byte_done;
	wire frame_evt = start_det | stop_det;
	wire ptr_load = rx_end & (ph_q == PH_PTR) & ~frame_evt;
	wire launch_wr = rx_end & (ph_q == PH_DATA);
	wire rd_first = (st_q == ST_RX_ACK) & scl_fall & (ph_q == PH_ADDR) & (dir_q == DIR_READ);
	wire rd_next = (st_q == ST_TX_ACK) & scl_fall & mack_q;
	wire launch = (launch_wr | rd_first | rd_next) & ~frame_evt;
	wire [7:0] ptr_inc = ptr_q + 8'h01;
	wire [3:0] cnt_inc = bit_cnt_q + 4'h1;
	wire [7:0] rx_shift = {shift_q[6:0], line_s_q.sda};
	wire [7:0] tx_shift = {shift_q[6:0], 1'b0};

	// request toward the register side; pointer steps after every access
	always_ff @(posedge link_clk or negedge lrstn) begin
		if (!lrstn) begin
			req_q <= '{write: 1'b0, addr: PTR_RESET, data: RDATA_RESET};
			req_tgl_q <= 1'b0;
			ptr_q <= PTR_RESET;
		end else if (launch) begin
			req_q <= '{write: launch_wr, addr: ptr_q, data: shift_q};
			req_tgl_q <= ~req_tgl_q;
			ptr_q <= ptr_inc;
		end else if (ptr_load) begin
			ptr_q <= shift_q;
		end
	end

	// hold the clock low while an access is outstanding
	always_ff @(posedge link_clk or negedge lrstn) begin
		if (!lrstn) begin
			pend_q <= 1'b0;
			scl_oe_q <= 1'b0;
		end else begin
			if (launch) begin
				pend_q <= 1'b1;
			end else if (ack_evt) begin
				pend_q <= 1'b0;
			end
			// lags pend by one cycle so read data is on sda before release
			scl_oe_q <= pend_q;
		end
	end

	// byte framing, acknowledge and data drive
	always_ff @(posedge link_clk or negedge lrstn) begin
		if (!lrstn) begin
			st_q <= ST_IDLE;
			ph_q <= PH_ADDR;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			dir_q <= 1'b0;
			mack_q <= 1'b0;
			sda_oe_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			// read data arrives while the clock is held low
			if (ack_evt && st_q == ST_TX) begin
				shift_q <= rdata_hold_q;
				sda_oe_q <= ~rdata_hold_q[7];
			end
			unique case (st_q)
				ST_RX: begin
					if (scl_rise) begin
						shift_q <= rx_shift;
						bit_cnt_q <= cnt_inc;
					end
					if (rx_end) begin
						bit_cnt_q <= 4'h0;
						if (ph_q != PH_ADDR || id_hit) begin
							sda_oe_q <= 1'b1;
							st_q <= ST_RX_ACK;
							dir_q <= shift_q[0];
						end else begin
							st_q <= ST_IGNORE;
						end
					end
				end
				ST_RX_ACK: begin
					if (scl_fall) begin
						sda_oe_q <= 1'b0;
						if (rd_first) begin
							st_q <= ST_TX;
						end else begin
							st_q <= ST_RX;
							ph_q <= (ph_q == PH_ADDR) ? PH_PTR : PH_DATA;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (last_tx_bit) begin
							bit_cnt_q <= 4'h0;
							sda_oe_q <= 1'b0;
							st_q <= ST_TX_ACK;
						end else begin
							bit_cnt_q <= cnt_inc;
							sda_oe_q <= ~shift_q[6];
							shift_q <= tx_shift;
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						mack_q <= ~line_s_q.sda;
					end
					if (scl_fall) begin
						st_q <= mack_q ? ST_TX : ST_IGNORE;
					end
				end
				ST_IDLE, ST_IGNORE: begin
				end
				default: begin
					st_q <= ST_IGNORE;
				end
			endcase
			// a start or stop overrides whatever the byte logic did
			if (start_det) begin
				st_q <= ST_RX;
				ph_q <= PH_ADDR;
				bit_cnt_q <= 4'h0;
				sda_oe_q <= 1'b0;
				busy_q <= 1'b1;
			end
			if (stop_det) begin
				st_q <= ST_IDLE;
				sda_oe_q <= 1'b0;
				busy_q <= 1'b0;
			end
		end
	end

	// output low levels are constant; only the enables move
	always_ff @(posedge link_clk or negedge lrstn) begin
		if (!lrstn) begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end else begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
		end
	end

	assign scl_oe = scl_oe_q;
	assign sda_oe = sda_oe_q;

	// ---------------- register side ----------------

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			req_m_q <= 1'b0;
			req_s_q <= 1'b0;
			req_p_q <= 1'b0;
			busy_m_q <= 1'b0;
			bus_busy <= 1'b0;
		end else begin
			req_m_q <= req_tgl_q;
			req_s_q <= req_m_q;
			req_p_q <= req_s_q;
			busy_m_q <= busy_q;
			bus_busy <= busy_m_q;
		end
	end

	wire req_evt = req_s_q ^ req_p_q;

	// request fields are stable for the whole handshake
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_wr_en <= 1'b0;
			reg_rd_en <= 1'b0;
			reg_addr <= PTR_RESET;
			reg_wdata <= RDATA_RESET;
		end else begin
			reg_wr_en <= req_evt & req_q.write;
			reg_rd_en <= req_evt & ~req_q.write;
			if (req_evt) begin
				reg_addr <= req_q.addr;
				reg_wdata <= req_q.data;
			end
		end
	end

	// read data is captured in the same clk cycle as the answer toggles back
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_tgl_q <= 1'b0;
			rdata_hold_q <= RDATA_RESET;
		end else begin
			if (reg_wr_en | reg_rd_en) begin
				ack_tgl_q <= ~ack_tgl_q;
			end
			if (reg_rd_en) begin
				rdata_hold_q <= reg_rdata;
			end
		end
	end

endmodule : i2csp_slave_port

// file: i2csp_slave_port_assertions.sv
// Purpose: pin-level checks for the two-wire slave port
// Assumes: open-drain lines with pull-ups
// Notes: line checks on link_clk, register strobes on clk
module i2csp_slave_port_assertions (
	input wire logic clk,
	input wire logic rstn,
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic bus_id_select_pin,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire i2csp_pkg::i2csp_byte_t reg_addr,
	input wire i2csp_pkg::i2csp_byte_t reg_wdata,
	input wire i2csp_pkg::i2csp_byte_t reg_rdata,
	input wire logic bus_busy
);
	import i2csp_pkg::*;
	property p_scl_low;
		@(posedge link_clk) disable iff (!rstn) scl_oe |-> !scl_o;
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("scl drive not low");
	property p_ack_hold;
		@(posedge link_clk) disable iff (!rstn) (sda_oe && scl_i && $past(scl_i)) |=> sda_oe;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("sda dropped in clock high");
	property p_sda_edge;
		@(posedge link_clk) disable iff (!rstn) $changed(sda_oe) |-> !scl_i && !$past(scl_i);
	endproperty
	a_sda_edge: assert property (p_sda_edge) else $error("sda moved in clock high");
	property p_stretch_low;
		@(posedge link_clk) disable iff (!rstn) $rose(scl_oe) |-> !scl_i;
	endproperty
	a_stretch_low: assert property (p_stretch_low) else $error("stretch in clock high");
	property p_stretch_end;
		@(posedge link_clk) disable iff (!rstn) $rose(scl_oe) |-> ##[1:40] !scl_oe;
	endproperty
	a_stretch_end: assert property (p_stretch_end) else $error("stretch never ends");
	property p_wr_hold;
		@(posedge clk) disable iff (!rstn)
			reg_wr_en |=> !reg_wr_en && $stable(reg_addr) && $stable(reg_wdata);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write strobe malformed");
	property p_rd_pulse;
		@(posedge clk) disable iff (!rstn) reg_rd_en |=> !reg_rd_en && $stable(reg_addr);
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe malformed");
	property p_busy;
		@(posedge clk) disable iff (!rstn) (reg_wr_en || reg_rd_en) |-> bus_busy;
	endproperty
	a_busy: assert property (p_busy) else $error("access while bus idle");
endmodule : i2csp_slave_port_assertions

bind i2csp_slave_port i2csp_slave_port_assertions i2csp_slave_port_assertions_i (.clk, .rstn,
	.link_clk, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .bus_id_select_pin,
	.reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .bus_busy);

// file: i2csp_master_model.sv
// Purpose: bus master model on the two-wire lines
// Assumes: lines pulled up in the bench
// Notes: quarter bit of 20 link_clk keeps the rate below 400kHz
module i2csp_master_model (
	input wire logic link_clk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_oe,
	output logic sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	task automatic tick();
		repeat (20) @(posedge link_clk);
		#1;
	endtask : tick
	task automatic rise();
		scl_oe = 1'b0;
		while (!scl) @(posedge link_clk);
		#1;
		tick();
	endtask : rise
	task automatic bit_io(input logic b, output logic r);
		sda_oe = !b;
		tick();
		rise();
		r = sda;
		tick();
		scl_oe = 1'b1;
		tick();
	endtask : bit_io
	task automatic start();
		sda_oe = 1'b0;
		tick();
		rise();
		sda_oe = 1'b1;
		tick();
		scl_oe = 1'b1;
		tick();
	endtask : start
	task automatic stop();
		sda_oe = 1'b1;
		tick();
		rise();
		sda_oe = 1'b0;
		tick();
	endtask : stop
	task automatic wr(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask : wr
	task automatic rd(output logic [7:0] b, input logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(!ack, r);
	endtask : rd
endmodule : i2csp_master_model

// file: testbench.sv
// Purpose: self-checking bench for the two-wire slave port
// Assumes: bench register file answers reads in the same clk cycle
// Notes: bus lines resolved here with pull-ups
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import i2csp_pkg::*;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic rstn = 1'b0;
	logic pin = 1'b0;
	logic scl_o, scl_oe, sda_o, sda_oe, m_scl, m_sda, wr_en, rd_en, busy, r;
	i2csp_byte_t addr, wdata, rdata, b;
	i2csp_byte_t mem [256];
	int fail_count = 0;
	int check_count = 0;
	int cyc = 0;
	int str_n = 0;
	int rd_n = 0;
	wire scl = !((scl_oe && !scl_o) || m_scl);
	wire sda = !((sda_oe && !sda_o) || m_sda);
	always #2.5 clk = ~clk;
	always #16 link_clk = ~link_clk;
	assign rdata = mem[addr];
	always @(posedge clk) if (wr_en) mem[addr] <= wdata;
	// count clock stretches and read strobes seen at the pins
	always @(posedge scl_oe) str_n++;
	always @(posedge clk) if (rd_en === 1'b1) rd_n++;
	i2csp_slave_port i2csp_slave_port_i (.clk, .rstn, .link_clk, .scl_i(scl), .scl_o, .scl_oe,
		.sda_i(sda), .sda_o, .sda_oe, .bus_id_select_pin(pin), .reg_wr_en(wr_en),
		.reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .bus_busy(busy));
	i2csp_master_model i2csp_master_model_i (.link_clk, .scl, .sda, .scl_oe(m_scl), .sda_oe(m_sda));
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic send(logic [7:0] v, logic e);
		i2csp_master_model_i.wr(v, r);
		chk("ack", {7'h0, r}, {7'h0, e});
	endtask : send
	task automatic t_write();
		int s0;
		s0 = str_n;
		i2csp_master_model_i.start();
		send({BUS_ID_UPPER, 2'b00}, 1'b1);
		chk("busy", {7'h0, busy}, 8'h01);
		send(8'h10, 1'b1);
		send(8'ha5, 1'b1);
		send(8'hc3, 1'b1);
		i2csp_master_model_i.stop();
		repeat (20) @(posedge clk);
		chk("idle", {7'h0, busy}, 8'h00);
		chk("m10", mem[8'h10], 8'ha5);
		chk("m11", mem[8'h11], 8'hc3);
		chk("stretch", 8'(str_n - s0), 8'h02);
		chk("low", {6'h0, scl_o, sda_o}, 8'h00);
	endtask : t_write
	task automatic t_read();
		int s0;
		int r0;
		s0 = str_n;
		r0 = rd_n;
		i2csp_master_model_i.start();
		send({BUS_ID_UPPER, 2'b00}, 1'b1);
		send(8'h10, 1'b1);
		i2csp_master_model_i.start();
		send({BUS_ID_UPPER, 1'b0, DIR_READ}, 1'b1);
		i2csp_master_model_i.rd(b, 1'b1);
		chk("rd0", b, 8'ha5);
		i2csp_master_model_i.rd(b, 1'b0);
		chk("rd1", b, 8'hc3);
		i2csp_master_model_i.stop();
		chk("rel", {7'h0, sda_oe}, 8'h00);
		chk("reads", 8'(rd_n - r0), 8'h02);
		chk("stretch", 8'(str_n - s0), 8'h02);
	endtask : t_read
	task automatic t_ignore();
		int s0;
		s0 = str_n;
		@(posedge clk);
		#1 pin = 1'b1;
		i2csp_master_model_i.start();
		send({BUS_ID_UPPER, 2'b00}, 1'b0);
		send(8'h20, 1'b0);
		send(8'h99, 1'b0);
		i2csp_master_model_i.stop();
		chk("m20", mem[8'h20], 8'h00);
		chk("quiet", 8'(str_n - s0), 8'h00);
		i2csp_master_model_i.start();
		for (int i = 0; i < 4; i++) i2csp_master_model_i.bit_io(i[0], r);
		i2csp_master_model_i.start();
		send({BUS_ID_UPPER, 2'b10}, 1'b1);
		send(8'h20, 1'b1);
		send(8'h77, 1'b1);
		i2csp_master_model_i.stop();
		chk("m20", mem[8'h20], 8'h77);
		chk("stretch", 8'(str_n - s0), 8'h01);
	endtask : t_ignore
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : summarize
	always @(posedge clk) begin
		cyc++;
		if (cyc == 95000) begin
			fail_count++;
			summarize();
		end
	end
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'h00;
		repeat (20) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (8) @(posedge link_clk);
		t_write();
		t_read();
		t_ignore();
		summarize();
	end
endmodule : testbench
